// ### logic/ptc_addr_match.sv
`timescale 1ns/100ps
module ptc_addr_match
    import ptc_pkg::*;
(
    input  wire logic [47:0]   dst_mac,
    input  wire ptc_port_cfg_t cfg,
    input  wire logic [47:0]   aux_mac,
    output logic               is_ptp
);

    always_comb begin
        is_ptp = 1'b0;
        if (cfg.primary_addr_enable && dst_mac == PTC_MAC_PRI) begin
            is_ptp = 1'b1;
        end
        if (cfg.alt_addr1_enable && dst_mac == PTC_MAC_ALT1) begin
            is_ptp = 1'b1;
        end
        if (cfg.alt_addr2_enable && dst_mac == PTC_MAC_ALT2) begin
            is_ptp = 1'b1;
        end
        if (cfg.alt_addr3_enable && dst_mac == PTC_MAC_ALT3) begin
            is_ptp = 1'b1;
        end
        if (cfg.user_addr_enable && dst_mac == aux_mac) begin
            is_ptp = 1'b1;
        end
    end

endmodule : ptc_addr_match

// ### logic/ptc_config_top.sv
`timescale 1ns/100ps
// How it works
// - Port 1 master stamps transmitted Sync and received Delay_Req.
// - Port 1 slave (reset) stamps transmitted Delay_Req and received Sync.
// - Port 1 primary enable (reset one) admits 01:00:5E:00:01:81.
// - Port 1 first alternate enable admits 01:00:5E:00:01:82; resets zero.
// - Port 1 second alternate enable admits 01:00:5E:00:01:83; resets zero.
// - Port 1 third alternate enable admits 01:00:5E:00:01:84; resets zero.
// - Port 1 user enable admits the programmed auxiliary address; resets zero.
// - Auxiliary address is 48 bits from a 16-bit high and 32-bit low register.
// - Port 1 rx lock keeps stored capture while rx interrupt is pending.
// - Port 1 tx lock keeps stored capture while tx interrupt is pending.
// - Host port master stamps transmitted Sync and received Delay_Req.
// - Host port slave (reset) stamps transmitted Delay_Req and received Sync.
// - Host port: from fabric counts as receive, toward fabric as transmit.
// - Host port primary enable (reset one) admits 01:00:5E:00:01:81.
module ptc_config_top
    import ptc_pkg::*;
(
    input  wire logic         clk,
    input  wire logic         arst_n,
    input  wire logic [11:0]  reg_addr,
    input  wire logic [31:0]  reg_wdata,
    input  wire logic         reg_wr,
    input  wire logic         reg_rd,
    output logic [31:0]       reg_rdata,
    input  wire logic [63:0]  clock_now,
    input  wire ptc_frame_t   p1_frame,
    input  wire logic         p0_valid,
    input  wire logic         p0_from_fabric,
    input  wire ptc_msg_t     p0_msg,
    input  wire logic [47:0]  p0_dst_mac,
    input  wire logic [79:0]  p0_source_identity,
    input  wire logic [15:0]  p0_seq_id,
    output ptc_capture_t      p1_rx_cap,
    output ptc_capture_t      p1_tx_cap,
    output ptc_capture_t      p0_rx_cap,
    output ptc_capture_t      p0_tx_cap,
    output logic              irq
);

    logic [31:0]            cfg_reg;
    logic [15:0]            aux_hi;
    logic [31:0]            aux_lo;
    logic [PTC_NUM_IRQ-1:0] int_sts;
    logic [PTC_NUM_IRQ-1:0] int_mask;
    logic [47:0]            aux_mac;
    ptc_port_cfg_t          p1_cfg;
    ptc_port_cfg_t          p0_cfg;
    ptc_frame_t             p0_frame;
    logic                   p1_ok;
    logic                   p0_ok;
    logic                   p1_rx_ev;
    logic                   p1_tx_ev;
    logic                   p0_rx_ev;
    logic                   p0_tx_ev;
    logic [PTC_NUM_IRQ-1:0] ev_vec;

    function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    assign aux_mac = {aux_hi, aux_lo};

    // Port 0 fields outside this block's scope are held inactive.
    assign p1_cfg = '{master_select:       cfg_reg[PTC_P1_MS_BIT],
                      primary_addr_enable: cfg_reg[PTC_P1_PRI_BIT],
                      alt_addr1_enable:    cfg_reg[PTC_P1_ALT1_BIT],
                      alt_addr2_enable:    cfg_reg[PTC_P1_ALT2_BIT],
                      alt_addr3_enable:    cfg_reg[PTC_P1_ALT3_BIT],
                      user_addr_enable:    cfg_reg[PTC_P1_USER_BIT],
                      lock_rx:             cfg_reg[PTC_P1_LKRX_BIT],
                      lock_tx:             cfg_reg[PTC_P1_LKTX_BIT]};
    assign p0_cfg = '{master_select:       cfg_reg[PTC_P0_MS_BIT],
                      primary_addr_enable: cfg_reg[PTC_P0_PRI_BIT],
                      default:             1'b0};

    // The host port sees the fabric side: frames from it are receive.
    assign p0_frame = '{valid:           p0_valid,
                        is_tx:           !p0_from_fabric,
                        msg:             p0_msg,
                        dst_mac:         p0_dst_mac,
                        source_identity: p0_source_identity,
                        seq_id:          p0_seq_id};

    ptc_addr_match u_p1_match (
        .dst_mac (p1_frame.dst_mac),
        .cfg     (p1_cfg),
        .aux_mac (aux_mac),
        .is_ptp  (p1_ok)
    );

    ptc_addr_match u_p0_match (
        .dst_mac (p0_frame.dst_mac),
        .cfg     (p0_cfg),
        .aux_mac (aux_mac),
        .is_ptp  (p0_ok)
    );

    ptc_port_capture u_p1_cap (
        .clk        (clk),
        .arst_n     (arst_n),
        .frame      (p1_frame),
        .addr_ok    (p1_ok),
        .cfg        (p1_cfg),
        .clock_now  (clock_now),
        .rx_pending (int_sts[PTC_IRQ_P1RX]),
        .tx_pending (int_sts[PTC_IRQ_P1TX]),
        .rx_event   (p1_rx_ev),
        .tx_event   (p1_tx_ev),
        .rx_cap     (p1_rx_cap),
        .tx_cap     (p1_tx_cap)
    );

    ptc_port_capture u_p0_cap (
        .clk        (clk),
        .arst_n     (arst_n),
        .frame      (p0_frame),
        .addr_ok    (p0_ok),
        .cfg        (p0_cfg),
        .clock_now  (clock_now),
        .rx_pending (int_sts[PTC_IRQ_P0RX]),
        .tx_pending (int_sts[PTC_IRQ_P0TX]),
        .rx_event   (p0_rx_ev),
        .tx_event   (p0_tx_ev),
        .rx_cap     (p0_rx_cap),
        .tx_cap     (p0_tx_cap)
    );

    assign ev_vec = {p0_tx_ev, p0_rx_ev, p1_tx_ev, p1_rx_ev};

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cfg_reg <= PTC_CONFIG_RESET;
        end else if (reg_wr && hit(reg_addr, PTC_CONFIG_OFS)) begin
            cfg_reg <= reg_wdata & PTC_CONFIG_MASK;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            aux_hi <= PTC_AUX_HI_RESET;
            aux_lo <= PTC_AUX_LO_RESET;
        end else if (reg_wr) begin
            if (hit(reg_addr, PTC_AUX_MAC_HI_OFS)) begin
                aux_hi <= reg_wdata[15:0];
            end
            if (hit(reg_addr, PTC_AUX_MAC_LO_OFS)) begin
                aux_lo <= reg_wdata;
            end
        end
    end

    // A capture in the same cycle as a write-one clear keeps its bit set.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            int_sts <= '0;
        end else begin
            if (reg_wr && hit(reg_addr, PTC_INT_STS_OFS)) begin
                int_sts <= (int_sts & ~reg_wdata[PTC_NUM_IRQ-1:0]) | ev_vec;
            end else begin
                int_sts <= int_sts | ev_vec;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            int_mask <= '0;
        end else if (reg_wr && hit(reg_addr, PTC_INT_MASK_OFS)) begin
            int_mask <= reg_wdata[PTC_NUM_IRQ-1:0];
        end
    end

    assign irq = |(int_sts & int_mask);

    // Unmapped addresses read as zero.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            case (reg_addr)
                PTC_AUX_MAC_HI_OFS: reg_rdata <= {16'h0000, aux_hi};
                PTC_AUX_MAC_LO_OFS: reg_rdata <= aux_lo;
                PTC_CONFIG_OFS:     reg_rdata <= cfg_reg;
                PTC_INT_STS_OFS:    reg_rdata <= {28'h0000000, int_sts};
                PTC_INT_MASK_OFS:   reg_rdata <= {28'h0000000, int_mask};
                default:            reg_rdata <= '0;
            endcase
        end else begin
            reg_rdata <= '0;
        end
    end

    a_p1_master_tx_sync: assert property (@(posedge clk) disable iff (!arst_n)
        (p1_frame.valid && p1_ok && p1_cfg.master_select && p1_frame.is_tx
         && p1_frame.msg == PTC_MSG_SYNC) |=> p1_tx_ev)
        else $error("Port 1 master missed Sync transmit capture.");

    a_p1_slave_rx_sync: assert property (@(posedge clk) disable iff (!arst_n)
        (p1_frame.valid && p1_ok && !p1_cfg.master_select && !p1_frame.is_tx
         && p1_frame.msg == PTC_MSG_SYNC) |=> p1_rx_ev)
        else $error("Port 1 slave missed Sync receive capture.");

    a_p1_no_addr: assert property (@(posedge clk) disable iff (!arst_n)
        !p1_ok |=> !(p1_rx_ev || p1_tx_ev))
        else $error("Port 1 captured a frame with no enabled address.");

    a_p1_pri_match: assert property (@(posedge clk) disable iff (!arst_n)
        (p1_frame.dst_mac == PTC_MAC_PRI) |-> (p1_ok == cfg_reg[PTC_P1_PRI_BIT]))
        else $error("Port 1 primary address match disagrees with enable.");

    a_p1_alt1_match: assert property (@(posedge clk) disable iff (!arst_n)
        (p1_frame.dst_mac == PTC_MAC_ALT1) |-> (p1_ok == cfg_reg[PTC_P1_ALT1_BIT]))
        else $error("Port 1 first alternate match disagrees with enable.");

    a_p1_user_match: assert property (@(posedge clk) disable iff (!arst_n)
        (p1_frame.dst_mac == aux_mac && cfg_reg[PTC_P1_USER_BIT]) |-> p1_ok)
        else $error("Port 1 auxiliary address not matched.");

    a_p1_rx_locked: assert property (@(posedge clk) disable iff (!arst_n)
        (p1_cfg.lock_rx && int_sts[PTC_IRQ_P1RX]) |=> $stable(p1_rx_cap))
        else $error("Port 1 rx capture overwritten under lock.");

    a_p1_tx_locked: assert property (@(posedge clk) disable iff (!arst_n)
        (p1_cfg.lock_tx && int_sts[PTC_IRQ_P1TX]) |=> $stable(p1_tx_cap))
        else $error("Port 1 tx capture overwritten under lock.");

    a_p0_fabric_rx: assert property (@(posedge clk) disable iff (!arst_n)
        (p0_valid && p0_ok && p0_from_fabric && !p0_cfg.master_select
         && p0_msg == PTC_MSG_SYNC) |=> (p0_rx_ev && !p0_tx_ev))
        else $error("Host port Sync from fabric not taken as receive.");

    a_p0_master_tx: assert property (@(posedge clk) disable iff (!arst_n)
        (p0_valid && p0_ok && !p0_from_fabric && p0_cfg.master_select
         && p0_msg == PTC_MSG_SYNC) |=> p0_tx_ev)
        else $error("Host port master missed Sync toward fabric.");

    a_p0_pri_match: assert property (@(posedge clk) disable iff (!arst_n)
        (p0_dst_mac == PTC_MAC_PRI) |-> (p0_ok == cfg_reg[PTC_P0_PRI_BIT]))
        else $error("Host port primary match disagrees with enable.");

    a_aux_read: assert property (@(posedge clk) disable iff (!arst_n)
        (reg_rd && reg_addr == PTC_AUX_MAC_HI_OFS)
        |=> reg_rdata == {16'h0000, aux_mac[47:32]})
        else $error("Auxiliary high read mismatch.");

    c_p1_rx: cover property (@(posedge clk) disable iff (!arst_n) p1_rx_ev);
    c_p1_tx_lock: cover property (@(posedge clk) disable iff (!arst_n)
        p1_tx_ev && int_sts[PTC_IRQ_P1TX]);
    c_p0_tx: cover property (@(posedge clk) disable iff (!arst_n) p0_tx_ev);
    c_irq: cover property (@(posedge clk) disable iff (!arst_n) irq);

endmodule : ptc_config_top

// ### logic/ptc_pkg.sv
package ptc_pkg;

    // Register byte offsets on the plain register port.
    localparam logic [11:0] PTC_AUX_MAC_HI_OFS  = 12'h18c;
    localparam logic [11:0] PTC_AUX_MAC_LO_OFS  = 12'h190;
    localparam logic [11:0] PTC_CONFIG_OFS      = 12'h194;
    localparam logic [11:0] PTC_INT_STS_OFS     = 12'h198;
    localparam logic [11:0] PTC_INT_MASK_OFS    = 12'h19c;

    // Field positions inside the configuration register.
    localparam int PTC_P1_MS_BIT    = 23;
    localparam int PTC_P1_PRI_BIT   = 22;
    localparam int PTC_P1_ALT1_BIT  = 21;
    localparam int PTC_P1_ALT2_BIT  = 20;
    localparam int PTC_P1_ALT3_BIT  = 19;
    localparam int PTC_P1_USER_BIT  = 18;
    localparam int PTC_P1_LKRX_BIT  = 17;
    localparam int PTC_P1_LKTX_BIT  = 16;
    localparam int PTC_P0_MS_BIT    = 15;
    localparam int PTC_P0_PRI_BIT   = 14;

    // Writable bits of the configuration register and their reset value.
    localparam logic [31:0] PTC_CONFIG_MASK  = 32'h00ffc000;
    localparam logic [31:0] PTC_CONFIG_RESET = 32'h00434000;
    localparam logic [15:0] PTC_AUX_HI_RESET = 16'h0000;
    localparam logic [31:0] PTC_AUX_LO_RESET = 32'h00000000;

    // Status bit positions: port 1 rx, port 1 tx, port 0 rx, port 0 tx.
    localparam int PTC_IRQ_P1RX = 0;
    localparam int PTC_IRQ_P1TX = 1;
    localparam int PTC_IRQ_P0RX = 2;
    localparam int PTC_IRQ_P0TX = 3;
    localparam int PTC_NUM_IRQ  = 4;

    // PTP multicast destinations.
    localparam logic [47:0] PTC_MAC_PRI  = 48'h01005e000181;
    localparam logic [47:0] PTC_MAC_ALT1 = 48'h01005e000182;
    localparam logic [47:0] PTC_MAC_ALT2 = 48'h01005e000183;
    localparam logic [47:0] PTC_MAC_ALT3 = 48'h01005e000184;

    typedef enum logic [1:0] {
        PTC_MSG_OTHER  = 2'b00,
        PTC_MSG_SYNC   = 2'b01,
        PTC_MSG_DLYREQ = 2'b10
    } ptc_msg_t;

    // One frame event seen by a port's timestamp unit.
    typedef struct packed {
        logic        valid;
        logic        is_tx;
        ptc_msg_t    msg;
        logic [47:0] dst_mac;
        logic [79:0] source_identity;
        logic [15:0] seq_id;
    } ptc_frame_t;

    // Per-port decoded configuration.
    typedef struct packed {
        logic master_select;
        logic primary_addr_enable;
        logic alt_addr1_enable;
        logic alt_addr2_enable;
        logic alt_addr3_enable;
        logic user_addr_enable;
        logic lock_rx;
        logic lock_tx;
    } ptc_port_cfg_t;

    // Stored capture of one direction.
    typedef struct packed {
        logic [63:0] clock;
        logic [79:0] source_identity;
        logic [15:0] seq_id;
    } ptc_capture_t;

endpackage : ptc_pkg

// ### logic/ptc_port_capture.sv
`timescale 1ns/100ps
module ptc_port_capture
    import ptc_pkg::*;
(
    input  wire logic          clk,
    input  wire logic          arst_n,
    input  wire ptc_frame_t    frame,
    input  wire logic          addr_ok,
    input  wire ptc_port_cfg_t cfg,
    input  wire logic [63:0]   clock_now,
    input  wire logic          rx_pending,
    input  wire logic          tx_pending,
    output logic               rx_event,
    output logic               tx_event,
    output ptc_capture_t       rx_cap,
    output ptc_capture_t       tx_cap
);

    logic want;
    logic rx_hit;
    logic tx_hit;

    // Master stamps outgoing Sync and incoming Delay_Req; slave the reverse.
    always_comb begin
        want = 1'b0;
        if (frame.valid && addr_ok) begin
            if (cfg.master_select) begin
                want = frame.is_tx ? (frame.msg == PTC_MSG_SYNC) : (frame.msg == PTC_MSG_DLYREQ);
            end else begin
                want = frame.is_tx ? (frame.msg == PTC_MSG_DLYREQ) : (frame.msg == PTC_MSG_SYNC);
            end
        end
    end

    assign rx_hit = want && !frame.is_tx;
    assign tx_hit = want && frame.is_tx;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rx_event <= 1'b0;
            tx_event <= 1'b0;
        end else begin
            rx_event <= rx_hit;
            tx_event <= tx_hit;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rx_cap <= '0;
        end else if (rx_hit && !(cfg.lock_rx && rx_pending)) begin
            rx_cap <= '{clock: clock_now, source_identity: frame.source_identity,
                        seq_id: frame.seq_id};
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tx_cap <= '0;
        end else if (tx_hit && !(cfg.lock_tx && tx_pending)) begin
            tx_cap <= '{clock: clock_now, source_identity: frame.source_identity,
                        seq_id: frame.seq_id};
        end
    end

endmodule : ptc_port_capture

// ### tb/tb_ptp_capture_port_config.sv
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin fail_count++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module tb_ptp_capture_port_config
    import ptc_pkg::*;
;
    logic         clk;
    logic         arst_n;
    logic [11:0]  reg_addr;
    logic [31:0]  reg_wdata;
    logic         reg_wr;
    logic         reg_rd;
    logic [31:0]  reg_rdata;
    logic [63:0]  clock_now;
    ptc_frame_t   p1_frame;
    logic         p0_valid;
    logic         p0_from_fabric;
    ptc_msg_t     p0_msg;
    logic [47:0]  p0_dst_mac;
    logic [79:0]  p0_source_identity;
    logic [15:0]  p0_seq_id;
    ptc_capture_t p1_rx_cap;
    ptc_capture_t p1_tx_cap;
    ptc_capture_t p0_rx_cap;
    ptc_capture_t p0_tx_cap;
    logic         irq;
    int           fail_count = 0;
    int           n_tests = 0;
    // Bench copies of what software has programmed and what the frames should have left.
    logic [31:0]  cfg_m = PTC_CONFIG_RESET;
    logic [47:0]  aux_m = 48'h0;
    logic [3:0]   sts_m = 4'h0;
    logic [3:0]   msk_m = 4'h0;
    ptc_capture_t ecap[4];
    logic [47:0]  addrs[6];
    logic [15:0]  seq = 16'h0100;

    ptc_config_top DUT (
        .clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .clock_now(clock_now),
        .p1_frame(p1_frame), .p0_valid(p0_valid), .p0_from_fabric(p0_from_fabric),
        .p0_msg(p0_msg), .p0_dst_mac(p0_dst_mac), .p0_source_identity(p0_source_identity),
        .p0_seq_id(p0_seq_id), .p1_rx_cap(p1_rx_cap), .p1_tx_cap(p1_tx_cap),
        .p0_rx_cap(p0_rx_cap), .p0_tx_cap(p0_tx_cap), .irq(irq)
    );

    always #2.5 clk = ~clk;

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : wrap_up

    task automatic reg_write(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
        if (a == PTC_CONFIG_OFS) cfg_m = d & PTC_CONFIG_MASK;
        if (a == PTC_AUX_MAC_HI_OFS) aux_m[47:32] = d[15:0];
        if (a == PTC_AUX_MAC_LO_OFS) aux_m[31:0] = d;
        if (a == PTC_INT_MASK_OFS) msk_m = d[3:0];
        if (a == PTC_INT_STS_OFS) sts_m = sts_m & ~d[3:0];
    endtask : reg_write

    task automatic reg_check(input logic [11:0] a, input logic [31:0] e, input string nm);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1;
        `CHK(nm, e, reg_rdata)
    endtask : reg_check

    // Sends one frame event and checks captures, status and irq against the bench model.
    task automatic send(input int port, input logic tx, input ptc_msg_t m, input logic [47:0] d);
        int   idx;
        logic ms;
        logic match;
        logic hit;
        logic lock;
        seq = seq + 16'h0001;
        idx = (port == 1) ? (tx ? PTC_IRQ_P1TX : PTC_IRQ_P1RX)
                          : (tx ? PTC_IRQ_P0TX : PTC_IRQ_P0RX);
        if (port == 1) begin
            ms    = cfg_m[PTC_P1_MS_BIT];
            match = (cfg_m[PTC_P1_PRI_BIT] && d == PTC_MAC_PRI) ||
                    (cfg_m[PTC_P1_ALT1_BIT] && d == PTC_MAC_ALT1) ||
                    (cfg_m[PTC_P1_ALT2_BIT] && d == PTC_MAC_ALT2) ||
                    (cfg_m[PTC_P1_ALT3_BIT] && d == PTC_MAC_ALT3) ||
                    (cfg_m[PTC_P1_USER_BIT] && d == aux_m);
        end else begin
            ms    = cfg_m[PTC_P0_MS_BIT];
            match = cfg_m[PTC_P0_PRI_BIT] && d == PTC_MAC_PRI;
        end
        hit  = match && (m == ((ms == tx) ? PTC_MSG_SYNC : PTC_MSG_DLYREQ));
        lock = (port == 1) && cfg_m[tx ? PTC_P1_LKTX_BIT : PTC_P1_LKRX_BIT] && sts_m[idx];
        if (hit && !lock) ecap[idx] = '{{4{seq}}, {5{seq}}, seq};
        if (hit) sts_m[idx] = 1'b1;
        @(posedge clk);
        clock_now <= {4{seq}};
        if (port == 1) begin
            p1_frame <= '{1'b1, tx, m, d, {5{seq}}, seq};
        end else begin
            p0_valid           <= 1'b1;
            p0_from_fabric     <= !tx;
            p0_msg             <= m;
            p0_dst_mac         <= d;
            p0_source_identity <= {5{seq}};
            p0_seq_id          <= seq;
        end
        @(posedge clk);
        p1_frame  <= '0;
        p0_valid  <= 1'b0;
        clock_now <= ~clock_now;
        @(posedge clk);
        #1;
        `CHK("p1_rx_cap", ecap[0], p1_rx_cap)
        `CHK("p1_tx_cap", ecap[1], p1_tx_cap)
        `CHK("p0_rx_cap", ecap[2], p0_rx_cap)
        `CHK("p0_tx_cap", ecap[3], p0_tx_cap)
        reg_check(PTC_INT_STS_OFS, {28'h0, sts_m}, "status");
        `CHK("irq", |(sts_m & msk_m), irq)
    endtask : send

    initial begin
        // A watchdog that expires counts as a mismatch.
        repeat (20000) @(posedge clk);
        fail_count++;
        $display("test watchdog expired");
        wrap_up();
    end

    initial begin
        clk = 1'b0;
        arst_n = 1'b0;
        reg_addr = 12'h000;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        clock_now = 64'h0;
        p1_frame = '0;
        p0_valid = 1'b0;
        p0_from_fabric = 1'b0;
        p0_msg = PTC_MSG_OTHER;
        p0_dst_mac = 48'h0;
        p0_source_identity = 80'h0;
        p0_seq_id = 16'h0;
        for (int i = 0; i < 4; i++) ecap[i] = '0;
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        reg_check(PTC_CONFIG_OFS, PTC_CONFIG_RESET, "config");
        reg_check(PTC_AUX_MAC_HI_OFS, 32'h0, "aux_hi");
        reg_check(PTC_AUX_MAC_LO_OFS, 32'h0, "aux_lo");
        reg_check(PTC_INT_STS_OFS, 32'h0, "status");
        reg_check(PTC_INT_MASK_OFS, 32'h0, "mask");
        reg_check(12'h000, 32'h0, "unmapped");
        `CHK("irq", 1'b0, irq)
        send(1, 1'b0, PTC_MSG_SYNC, PTC_MAC_PRI);
        $display("test reset done");
        reg_write(PTC_CONFIG_OFS, 32'hffffffff);
        reg_check(PTC_CONFIG_OFS, PTC_CONFIG_MASK, "config");
        reg_write(PTC_AUX_MAC_HI_OFS, 32'h00000a1b);
        reg_write(PTC_AUX_MAC_LO_OFS, 32'h2c3d4e5f);
        reg_check(PTC_AUX_MAC_HI_OFS, 32'h00000a1b, "aux_hi");
        reg_check(PTC_AUX_MAC_LO_OFS, 32'h2c3d4e5f, "aux_lo");
        reg_write(12'h1a0, 32'hffffffff);
        reg_check(12'h1a0, 32'h0, "unmapped");
        $display("test registers done");
        // Locks are off here so that every matching frame must overwrite its capture.
        reg_write(PTC_INT_MASK_OFS, 32'h5);
        for (int ms = 0; ms < 2; ms++) begin
            reg_write(PTC_CONFIG_OFS, ms ? 32'h00c0c000 : 32'h00404000);
            for (int p = 0; p < 2; p++)
                for (int tx = 0; tx < 2; tx++)
                    for (int k = 0; k < 3; k++)
                        send(p, tx[0], ptc_msg_t'(k), PTC_MAC_PRI);
        end
        $display("test direction done");
        addrs = '{PTC_MAC_PRI, PTC_MAC_ALT1, PTC_MAC_ALT2, PTC_MAC_ALT3, aux_m,
                  {16'h0a1a, 32'h2c3d4e5f}};
        for (int e = 0; e < 6; e++) begin
            reg_write(PTC_CONFIG_OFS, (e < 5 ? (32'h1 << (22 - e)) : 32'h0) |
                                      (e == 0 ? 32'h00004000 : 32'h0));
            for (int a = 0; a < 6; a++) begin
                send(1, 1'b0, PTC_MSG_SYNC, addrs[a]);
                send(0, 1'b0, PTC_MSG_SYNC, addrs[a]);
            end
        end
        $display("test addresses done");
        reg_write(PTC_INT_STS_OFS, 32'hf);
        reg_write(PTC_CONFIG_OFS, PTC_CONFIG_RESET);
        reg_write(PTC_INT_MASK_OFS, 32'hf);
        for (int r = 0; r < 2; r++) begin
            send(1, 1'b0, PTC_MSG_SYNC, PTC_MAC_PRI);
            send(1, 1'b0, PTC_MSG_SYNC, PTC_MAC_PRI);
            send(1, 1'b1, PTC_MSG_DLYREQ, PTC_MAC_PRI);
            send(1, 1'b1, PTC_MSG_DLYREQ, PTC_MAC_PRI);
            send(0, 1'b0, PTC_MSG_SYNC, PTC_MAC_PRI);
            send(0, 1'b0, PTC_MSG_SYNC, PTC_MAC_PRI);
            reg_write(PTC_INT_STS_OFS, 32'hf);
            #1;
            `CHK("irq", 1'b0, irq)
        end
        send(1, 1'b1, PTC_MSG_DLYREQ, PTC_MAC_PRI);
        reg_write(PTC_INT_MASK_OFS, 32'h0);
        send(1, 1'b1, PTC_MSG_OTHER, PTC_MAC_PRI);
        $display("test lock and interrupt done");
        wrap_up();
    end
endmodule : tb_ptp_capture_port_config
